//--- verilog/fam_pkg.sv
/*
 * Constants for the flag and data move execution block: register map,
 * instruction word fields, opcodes, flag positions, pointer layout, cycle counts.
 * Assumes a 32-bit AHB-Lite register bus and an 8-bit data memory.
 */
package fam_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam logic [31:0] OFS_INSTR  = 32'h0000_0000;
    localparam logic [31:0] OFS_FLAGS  = 32'h0000_0004;
    localparam logic [31:0] OFS_STATUS = 32'h0000_0008;
    localparam logic [31:0] OFS_RSEL   = 32'h0000_000c;
    localparam logic [31:0] OFS_RDATA  = 32'h0000_0010;

    localparam logic [7:0]  FLAGS_RST  = 8'h00;
    localparam logic [7:0]  GPR_RST    = 8'h00;
    localparam logic [4:0]  RSEL_RST   = 5'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Instruction word fields
    localparam int OP_MSB   = 31;
    localparam int OP_LSB   = 26;
    localparam int RD_MSB   = 25;
    localparam int RD_LSB   = 21;
    localparam int SRC_MSB  = 20;
    localparam int SRC_LSB  = 16;
    localparam int IMM_MSB  = 15;
    localparam int BIT_MSB  = 2;
    localparam int PTR_MSB  = 9;
    localparam int PTR_LSB  = 8;
    localparam int MODE_MSB = 11;
    localparam int MODE_LSB = 10;
    localparam int Q_MSB    = 5;

    localparam logic [5:0] OP_NOP  = 6'h00;
    localparam logic [5:0] OP_BSET = 6'h01;
    localparam logic [5:0] OP_BCLR = 6'h02;
    localparam logic [5:0] OP_B2T    = 6'h03;
    localparam logic [5:0] OP_T2B    = 6'h04;
    localparam logic [5:0] OP_HSET   = 6'h05;
    localparam logic [5:0] OP_HCLR   = 6'h06;
    localparam logic [5:0] OP_VSET   = 6'h07;
    localparam logic [5:0] OP_VCLR   = 6'h08;
    localparam logic [5:0] OP_SSET   = 6'h09;
    localparam logic [5:0] OP_SCLR   = 6'h0a;
    localparam logic [5:0] OP_MOV    = 6'h0b;
    localparam logic [5:0] OP_MOVW   = 6'h0c;
    localparam logic [5:0] OP_LDI    = 6'h0d;
    localparam logic [5:0] OP_ILOAD  = 6'h0e;
    localparam logic [5:0] OP_DLOAD  = 6'h0f;
    localparam logic [5:0] OP_KLOAD  = 6'h10;
    localparam logic [5:0] OP_IWRITE = 6'h11;

    ////////////////////////////////////////////////////////////////////////////
    // Flag positions in the flag register
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // Pointer pairs and addressing modes
    localparam logic [1:0] PTR_X      = 2'h0;
    localparam logic [1:0] PTR_Y      = 2'h1;
    localparam logic [1:0] PTR_Z      = 2'h2;
    localparam logic [4:0] PTR_BASE   = 5'h1a;
    localparam logic [1:0] MODE_PLAIN = 2'h0;
    localparam logic [1:0] MODE_POST  = 2'h1;
    localparam logic [1:0] MODE_PRE   = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Cycle counts and status layout
    localparam logic [3:0] CYC_SHORT  = 4'h1;
    localparam logic [3:0] CYC_MEM    = 4'h2;
    localparam int         HTRANS_ACT = 1;

    typedef enum logic {FAM_IDLE, FAM_MEM} fam_state_t;

endpackage

//--- verilog/fam_mem_if.sv
/*
 * Interface between the execution core and its data memory.
 * Assumes one clock; memory reads return data at the next edge.
 */
`timescale 1ns/10ps
interface fam_mem_if;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
    logic [7:0]  rdata;

    modport core (output addr, output wdata, output we, output re, input rdata);
    modport mem  (input addr, input wdata, input we, input re, output rdata);
endinterface

//--- verilog/fam_data_mem.sv
/*
 * Internal data memory, byte wide, synchronous read and write.
 * Assumes the core holds requests for one cycle only; upper address bits are ignored.
 */
`timescale 1ns/10ps
module fam_data_mem
#(
    parameter int AW = 8
)
(
    input wire logic hclk,
    input wire logic hresetn,
    fam_mem_if.mem   bus
);

    logic [7:0] mem_array [0:(1<<AW)-1];
    wire  [AW-1:0] index = bus.addr[AW-1:0];

    always_ff @(posedge hclk)
    begin
        if (bus.we)
            mem_array[index] <= bus.wdata;
    end

    // No reset on the array itself, only on the read port
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            bus.rdata <= 8'h00;
        else if (bus.re)
            bus.rdata <= mem_array[index];
    end

endmodule // fam_data_mem

//--- verilog/fam_core.sv
/*
 * Flag and data move execution unit with an AHB-Lite register slave.
 * Assumes a single AHB-Lite master, word transfers only, hready tied to hreadyout.
 */
// Summary of operation
// - Bit copy to T flag takes the chosen source bit, one cycle.
// - T flag copy writes the chosen destination bit, flags unchanged, one cycle.
// - Half-carry set and clear touch only that flag, one cycle each.
// - Overflow set forces V to one only, one cycle.
// - Overflow clear forces V to zero only, one cycle.
// - Sign set forces S to one only, one cycle.
// - Sign clear forces S to zero only, one cycle.
// - Post-increment load reads at pointer, then bumps pointer, two cycles, flags kept.
// - Pre-decrement load drops pointer first, reads at new value, two cycles.
// - Displaced load reads pointer plus offset, pointer kept, two cycles.
// - Direct load reads immediate address, two cycles, no flag changes.
// - Post-increment store writes at pointer, then bumps pointer, two cycles.
// - Pre-decrement store drops pointer first, writes at new value, two cycles.
`timescale 1ns/10ps
module fam_core
    import fam_pkg::*;
#(
    parameter int MEM_AW = 8
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [7:0]  flag_register
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [7:0]  gpr [0:31];
    fam_state_t  state;
    logic        dp_valid;
    logic        dp_write;
    logic [31:0] dp_addr;
    logic [31:0] last_instr;
    logic [4:0]  rsel;
    logic [4:0]  load_dst;
    logic        load_pend;
    logic [3:0]  last_cycles;
    logic [15:0] exec_count;
    logic [7:0]  next_flags;

    fam_mem_if mem_bus ();

    fam_data_mem #(.AW(MEM_AW)) u_mem
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .bus     (mem_bus.mem)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire addr_accept = hsel & htrans[HTRANS_ACT] & hready;
    wire wr_fire     = dp_valid & dp_write & hreadyout;
    wire read_wait   = dp_valid & ~dp_write;
    wire read_load   = read_wait & ~hreadyout & (state == FAM_IDLE);
    wire sel_instr   = dp_addr == OFS_INSTR;
    wire sel_flags   = dp_addr == OFS_FLAGS;
    wire sel_rsel    = dp_addr == OFS_RSEL;
    wire sel_rdata   = dp_addr == OFS_RDATA;
    wire sel_status  = dp_addr == OFS_STATUS;
    wire exec        = wr_fire & sel_instr;

    // Unmapped or misaligned addresses read as zero
    wire [31:0] read_word = sel_instr  ? last_instr :
                            sel_flags  ? {24'h000000, flag_register} :
                            sel_status ? {exec_count, 8'h00, last_cycles, 3'h0, state == FAM_MEM} :
                            sel_rsel   ? {27'h0000000, rsel} :
                            sel_rdata  ? {24'h000000, gpr[rsel]} : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Instruction fields
    wire [5:0]  op       = hwdata[OP_MSB:OP_LSB];
    wire [4:0]  rd_idx   = hwdata[RD_MSB:RD_LSB];
    wire [4:0]  src_idx  = hwdata[SRC_MSB:SRC_LSB];
    wire [15:0] imm      = hwdata[IMM_MSB:0];
    wire [2:0]  bit_sel  = hwdata[BIT_MSB:0];
    wire [1:0]  ptr_raw  = hwdata[PTR_MSB:PTR_LSB];
    wire [1:0]  mode     = hwdata[MODE_MSB:MODE_LSB];
    wire [5:0]  q        = hwdata[Q_MSB:0];
    wire [7:0]  src_val  = gpr[src_idx];
    wire        src_bit  = src_val[bit_sel];
    wire        t_flag   = flag_register[FLAG_T];
    wire [4:0]  rd_even  = {rd_idx[4:1], 1'b0};
    wire [4:0]  rd_odd   = {rd_idx[4:1], 1'b1};
    wire [4:0]  src_even = {src_idx[4:1], 1'b0};
    wire [4:0]  src_odd  = {src_idx[4:1], 1'b1};

    ////////////////////////////////////////////////////////////////////////////
    // Pointer arithmetic, full pair width
    wire [1:0]  ptr_code   = (ptr_raw == 2'h3) ? PTR_Z : ptr_raw;
    wire [4:0]  ptr_lo_idx = PTR_BASE + {2'b00, ptr_code, 1'b0};
    wire [4:0]  ptr_hi_idx = ptr_lo_idx + 5'h01;
    wire [15:0] ptr_val    = {gpr[ptr_hi_idx], gpr[ptr_lo_idx]};
    wire [7:0]  ptr_hi_val = ptr_val[15:8];
    wire [15:0] ptr_inc    = ptr_val + 16'h0001;
    wire [15:0] ptr_dec    = ptr_val - 16'h0001;
    wire [15:0] ldd_addr   = ptr_val + {10'h000, q};

    wire is_iload  = op == OP_ILOAD;
    wire is_dload  = op == OP_DLOAD;
    wire is_kload  = op == OP_KLOAD;
    wire is_iwrite = op == OP_IWRITE;
    wire is_load   = is_iload | is_dload | is_kload;
    wire mem_op    = exec & (is_load | is_iwrite);
    wire ptr_step  = exec & (is_iload | is_iwrite) & ((mode == MODE_POST) | (mode == MODE_PRE));
    wire [15:0] ptr_next = (mode == MODE_PRE) ? ptr_dec : ptr_inc;

    // Pre-decrement addresses the updated pointer, post-increment the old one
    wire [15:0] eff_addr = is_kload ? imm :
                           is_dload ? ldd_addr :
                           (mode == MODE_PRE) ? ptr_dec : ptr_val;

    assign mem_bus.addr  = eff_addr;
    assign mem_bus.wdata = src_val;
    assign mem_bus.we    = exec & is_iwrite;
    assign mem_bus.re    = exec & is_load;

    // One wait for every read, another while a memory op is in flight
    wire next_hreadyout = (addr_accept & ~hwrite) ? 1'b0 :
                          mem_op ? 1'b0 :
                          (state == FAM_MEM) ? ~read_wait : 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Flag updates
    always_comb
    begin
        next_flags = flag_register;
        if (wr_fire & sel_flags)
            next_flags = hwdata[7:0];
        else if (exec)
            case (op)
                OP_BSET: next_flags[bit_sel] = 1'b1;
                OP_BCLR: next_flags[bit_sel] = 1'b0;
                OP_B2T:  next_flags[FLAG_T]  = src_bit;
                OP_HSET: next_flags[FLAG_H]  = 1'b1;
                OP_HCLR: next_flags[FLAG_H]  = 1'b0;
                OP_VSET: next_flags[FLAG_V]  = 1'b1;
                OP_VCLR: next_flags[FLAG_V]  = 1'b0;
                OP_SSET: next_flags[FLAG_S]  = 1'b1;
                OP_SCLR: next_flags[FLAG_S]  = 1'b0;
                default: next_flags = flag_register;
            endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            flag_register <= FLAGS_RST;
        else
            flag_register <= next_flags;
    end

    ////////////////////////////////////////////////////////////////////////////
    // General registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < 32; i++)
                gpr[i] <= GPR_RST;
        end
        else
        begin
            if (ptr_step)
            begin
                gpr[ptr_lo_idx] <= ptr_next[7:0];
                gpr[ptr_hi_idx] <= ptr_next[15:8];
            end
            if (exec)
                case (op)
                    OP_T2B:  gpr[rd_idx][bit_sel] <= t_flag;
                    OP_MOV:  gpr[rd_idx] <= src_val;
                    OP_MOVW:
                    begin
                        gpr[rd_even] <= gpr[src_even];
                        gpr[rd_odd]  <= gpr[src_odd];
                    end
                    OP_LDI:  gpr[rd_idx] <= imm[7:0];
                    default: ;
                endcase
            if (wr_fire & sel_rdata)
                gpr[rsel] <= hwdata[7:0];
            // Load data lands after any pointer step of the same op
            if ((state == FAM_MEM) & load_pend)
                gpr[load_dst] <= mem_bus.rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer and bookkeeping
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state     <= FAM_IDLE;
            load_pend <= 1'b0;
            load_dst  <= 5'h00;
        end
        else if (mem_op)
        begin
            state     <= FAM_MEM;
            load_pend <= is_load;
            load_dst  <= rd_idx;
        end
        else
            state <= FAM_IDLE;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            last_instr  <= 32'h0000_0000;
            last_cycles <= 4'h0;
            exec_count  <= 16'h0000;
            rsel        <= RSEL_RST;
        end
        else
        begin
            if (exec)
            begin
                last_instr  <= hwdata;
                last_cycles <= mem_op ? CYC_MEM : CYC_SHORT;
                exec_count  <= exec_count + 16'h0001;
            end
            if (wr_fire & sel_rsel)
                rsel <= hwdata[4:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr  <= 32'h0000_0000;
        end
        else if (hready)
        begin
            dp_valid <= addr_accept;
            dp_write <= hwrite;
            dp_addr  <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= next_hreadyout;
            if (read_load)
                hrdata <= read_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_bit_to_flag: assert property (exec && op == OP_B2T |=> t_flag == $past(src_bit)
        && ((flag_register ^ $past(flag_register)) & ~(8'h01 << FLAG_T)) == 8'h00)
        else $error("bit copy to T flag wrong");
    a_flag_to_bit: assert property (exec && op == OP_T2B |=>
        gpr[$past(rd_idx)][$past(bit_sel)] == $past(t_flag) && $stable(flag_register))
        else $error("T flag copy to register wrong");
    a_half_set: assert property (exec && op == OP_HSET |=> flag_register[FLAG_H]
        && ((flag_register ^ $past(flag_register)) & ~(8'h01 << FLAG_H)) == 8'h00)
        else $error("half carry set wrong");
    a_half_clear: assert property (exec && op == OP_HCLR |=> !flag_register[FLAG_H]
        && ((flag_register ^ $past(flag_register)) & ~(8'h01 << FLAG_H)) == 8'h00)
        else $error("half carry clear wrong");
    a_ovf_set: assert property (exec && op == OP_VSET |=> flag_register == ($past(flag_register) | (8'h01 << FLAG_V)))
        else $error("overflow set wrong");
    a_ovf_clear: assert property (exec && op == OP_VCLR |=> flag_register == ($past(flag_register) & ~(8'h01 << FLAG_V)))
        else $error("overflow clear wrong");
    a_sign_set: assert property (exec && op == OP_SSET |=> flag_register == ($past(flag_register) | (8'h01 << FLAG_S)))
        else $error("sign set wrong");
    a_sign_clear: assert property (exec && op == OP_SCLR |=> flag_register == ($past(flag_register) & ~(8'h01 << FLAG_S)))
        else $error("sign clear wrong");
    a_load_postinc: assert property (exec && is_iload && mode == MODE_POST |-> mem_bus.re && mem_bus.addr == ptr_val
        ##1 {gpr[$past(ptr_hi_idx)], gpr[$past(ptr_lo_idx)]} == $past(ptr_inc) && state == FAM_MEM
        ##1 state == FAM_IDLE && gpr[$past(load_dst)] == $past(mem_bus.rdata) && $stable(flag_register))
        else $error("post-increment load wrong");
    a_load_predec: assert property (exec && is_iload && mode == MODE_PRE |-> mem_bus.addr == ptr_dec
        ##1 {gpr[$past(ptr_hi_idx)], gpr[$past(ptr_lo_idx)]} == $past(ptr_dec) ##1 state == FAM_IDLE)
        else $error("pre-decrement load wrong");
    a_disp_keep: assert property (exec && is_dload |-> mem_bus.addr == ldd_addr
        ##1 {gpr[$past(ptr_hi_idx)], gpr[$past(ptr_lo_idx)]} == $past(ptr_val) ##1 state == FAM_IDLE)
        else $error("displaced load wrong");
    a_direct_two: assert property (exec && is_kload |-> mem_bus.addr == imm
        ##1 !hreadyout && state == FAM_MEM ##1 state == FAM_IDLE && $stable(flag_register))
        else $error("direct load timing wrong");
    a_write_postinc: assert property (exec && is_iwrite && mode == MODE_POST |-> mem_bus.we && mem_bus.wdata == src_val
        && mem_bus.addr == ptr_val ##1 {gpr[$past(ptr_hi_idx)], gpr[$past(ptr_lo_idx)]} == $past(ptr_inc)
        ##1 state == FAM_IDLE)
        else $error("post-increment store wrong");
    a_write_predec: assert property (exec && is_iwrite && mode == MODE_PRE |-> mem_bus.we && mem_bus.addr == ptr_dec
        ##1 {gpr[$past(ptr_hi_idx)], gpr[$past(ptr_lo_idx)]} == $past(ptr_dec))
        else $error("pre-decrement store wrong");
    a_move_single: assert property (exec && (op == OP_MOV || op == OP_MOVW || op == OP_LDI) |=>
        state == FAM_IDLE && $stable(flag_register) && last_cycles == CYC_SHORT)
        else $error("move not single cycle");
    a_ptr_carry: assert property (ptr_step && mode == MODE_POST && ptr_val[7:0] == 8'hff |=>
        gpr[$past(ptr_hi_idx)] == $past(ptr_hi_val) + 8'h01 && gpr[$past(ptr_lo_idx)] == 8'h00)
        else $error("pointer carry lost");

    c_load_post: cover property (exec && is_iload && mode == MODE_POST ##2 read_load);
    c_write_pre: cover property (exec && is_iwrite && mode == MODE_PRE);
    c_bit_copy: cover property (exec && op == OP_B2T ##1 exec && op == OP_T2B);
    c_borrow: cover property (ptr_step && mode == MODE_PRE && ptr_val[7:0] == 8'h00);

endmodule // fam_core

//--- dv/fam_ahb_master.sv
/*
 * AHB-Lite master model, the party that faces the register slave.
 * Assumes hready is looped back from the slave's hreadyout.
 */
`timescale 1ns/10ps
module fam_ahb_master
(
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata,
    output logic             stuck
);
    initial
    begin
        {hsel, haddr, htrans, hwrite, hsize, hwdata, stuck} = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bounded wait, a hung slave raises stuck
    task automatic wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hready !== 1'b1 && n < 40);
        if (hready !== 1'b1)
            stuck <= 1'b1;
    endtask

    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask
endmodule // fam_ahb_master

//--- dv/tb.sv
/*
 * Self-checking bench: a register model of the flag and move unit.
 * Assumes the AHB-Lite master model and the package constants.
 */
`timescale 1ns/10ps
module tb
    import fam_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, stuck;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  flag_register, fl;
    logic [7:0]  gpr [32];
    logic [7:0]  mem [256];
    logic [5:0]  fop [6] = '{OP_HSET, OP_HCLR, OP_VSET, OP_VCLR, OP_SSET, OP_SCLR};
    logic [2:0]  fbit [6] = '{FLAG_H, FLAG_H, FLAG_V, FLAG_V, FLAG_S, FLAG_S};
    logic [31:0] v;
    int          n_fail, n_checks, seed;

    always #10 hclk = ~hclk;

    fam_core #(.MEM_AW(8)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .flag_register(flag_register));

    fam_ahb_master m (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .stuck(stuck));

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [31:0] a);
        m.xfer(1'b0, a, 32'h0, v);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        m.xfer(1'b1, a, d, r);
    endtask

    task automatic exec(input logic [5:0] op, input logic [4:0] rd5, input logic [4:0] src5, input logic [15:0] imm);
        wr(OFS_INSTR, {op, rd5, src5, imm});
    endtask

    task automatic chkreg(input int i);
        wr(OFS_RSEL, 32'(i));
        rd(OFS_RDATA);
        chk(v, {24'h0, gpr[i]});
    endtask

    task automatic chkfl;
        rd(OFS_FLAGS);
        chk(v, {24'h0, fl});
        chk({24'h0, flag_register}, {24'h0, fl});
    endtask

    task automatic cyc(input logic [3:0] n);
        rd(OFS_STATUS);
        chk({28'h0, v[7:4]}, {28'h0, n});
    endtask

    task automatic setreg(input int i, input logic [7:0] k);
        exec(OP_LDI, 5'(i), 5'h0, {8'h0, k});
        gpr[i] = k;
    endtask

    // Pointer model works on the whole pair so carries cross bytes
    task automatic mop(input logic [5:0] op, input int r, input logic [15:0] imm);
        int lo, md, pv, a;
        lo = 26 + 2 * ((imm[9:8] == 2'h3) ? 2 : int'(imm[9:8]));
        md = (op == OP_ILOAD || op == OP_IWRITE) ? int'(imm[11:10]) : 0;
        pv = {gpr[lo + 1], gpr[lo]};
        if (md == 2)
            pv = (pv - 1) & 'hffff;
        a = (op == OP_KLOAD) ? int'(imm) : (op == OP_DLOAD) ? pv + int'(imm[5:0]) : pv;
        if (op == OP_IWRITE)
            mem[a & 255] = gpr[r];
        else
            gpr[r] = mem[a & 255];
        if (md == 1)
            pv = (pv + 1) & 'hffff;
        gpr[lo] = 8'(pv);
        gpr[lo + 1] = 8'(pv >> 8);
        exec(op, (op == OP_IWRITE) ? 5'h0 : 5'(r), (op == OP_IWRITE) ? 5'(r) : 5'h0, imm);
        cyc(CYC_MEM);
        chkreg(r);
        chkreg(lo);
        chkreg(lo + 1);
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge stuck)
    begin
        n_fail++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        hclk = 1'b0;
        hresetn = 1'b0;
        seed = 47;
        fl = FLAGS_RST;
        foreach (gpr[i])
            gpr[i] = GPR_RST;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chkfl();
        chkreg(5);
        rd(32'h0000_0020);
        chk(v, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 6; i++)
        begin
            fl = 8'($random(seed));
            wr(OFS_FLAGS, {24'h0, fl});
            exec(fop[i], 5'h0, 5'h0, 16'h0);
            fl[fbit[i]] = (i % 2 == 0);
            chkfl();
            cyc(CYC_SHORT);
        end
        exec(OP_BSET, 5'h0, 5'h0, 16'(FLAG_C));
        fl[FLAG_C] = 1'b1;
        chkfl();
        exec(OP_BCLR, 5'h0, 5'h0, 16'(FLAG_I));
        fl[FLAG_I] = 1'b0;
        chkfl();
        $display("test flag ops done");
        for (int i = 16; i < 20; i++)
        begin
            setreg(i, 8'($random(seed)));
            chkreg(i);
        end
        exec(OP_MOV, 5'd1, 5'd16, 16'h0);
        gpr[1] = gpr[16];
        chkreg(1);
        cyc(CYC_SHORT);
        exec(OP_MOVW, 5'd2, 5'd18, 16'h0);
        gpr[2] = gpr[18];
        gpr[3] = gpr[19];
        chkreg(2);
        chkreg(3);
        chkfl();
        $display("test moves done");
        for (int b = 0; b < 8; b++)
        begin
            exec(OP_B2T, 5'h0, 5'd16, 16'(b));
            fl[FLAG_T] = gpr[16][b];
            chkfl();
            exec(OP_T2B, 5'd4, 5'h0, 16'(b));
            gpr[4][b] = fl[FLAG_T];
            chkreg(4);
            chkfl();
        end
        $display("test bit copy done");
        setreg(26, 8'hff);
        setreg(27, 8'h00);
        setreg(28, 8'hf0);
        setreg(29, 8'h00);
        mop(OP_IWRITE, 16, 16'h0400);
        mop(OP_IWRITE, 17, 16'h0400);
        mop(OP_ILOAD, 5, 16'h0800);
        mop(OP_ILOAD, 6, 16'h0800);
        mop(OP_ILOAD, 7, 16'h0400);
        mop(OP_DLOAD, 8, 16'h010f);
        mop(OP_KLOAD, 9, 16'h0000);
        mop(OP_IWRITE, 18, 16'h0800);
        mop(OP_ILOAD, 10, 16'h0000);
        chkfl();
        $display("test memory moves done");
        end_of_test();
    end
endmodule // tb
